//--- bench/test_timer3_counter_16bit.sv
`timescale 1ns/10ps
module test_timer3_counter_16bit;
   import tmrtc_pkg::*;
   logic sys_clk = 1'b0, nrst = 1'b0, pin_run = 1'b0, trig_req = 1'b0;
   logic pin, trig, awready, wready, bvalid, arready, rvalid, irq;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   // The response channels are always ready, so back to back calls never toggle them.
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
   logic [31:0] wdata = 32'h0, rdata, rd_q;
   logic [1:0] bresp, rresp, resp_q, ccp;
   int fail_count = 0;
   int samples_checked = 0;
   always #2 sys_clk = !sys_clk;  // 250 MHz.
   tmrtc_far_side i_far (.sys_clk(sys_clk), .nrst(nrst), .pin_run(pin_run),
      .trig_req(trig_req), .external_count_pin(pin), .special_event_trigger(trig));
   tmrtc_timer i_dut (.sys_clk(sys_clk), .nrst(nrst), .external_count_pin(pin),
      .special_event_trigger(trig), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ccp_time_base(ccp), .timer_irq(irq));
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // A range check absorbs the one-tick phase uncertainty of a free-running divider.
   task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      samples_checked++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask : chk_rng
   // Both channels are offered together and each dropped when taken.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      resp_q = bresp;
      if (n == 100) begin
         fail_count++;
         report_and_stop();
      end
   endtask : wr
   task automatic rd(input logic [11:0] a);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      rd_q = rdata;
      resp_q = rresp;
      if (n == 100) begin
         fail_count++;
         report_and_stop();
      end
   endtask : rd
   // Reads the count low byte first, then the high byte.
   task automatic rd_count(output logic [31:0] c);
      logic [31:0] lo;
      rd(TMRTC_LOW_BYTE);
      lo = rd_q;
      rd(TMRTC_HIGH_BYTE);
      c = {rd_q[23:0], lo[7:0]};
   endtask : rd_count
   task automatic sc_reset_map();
      rd(TMRTC_CTRL_BYTE);
      chk(rd_q, {24'h0, TMRTC_CTRL_RESET});
      rd(12'h0FC);
      chk({30'h0, resp_q}, {30'h0, TMRTC_RESP_SLVERR});
      wr(TMRTC_HIGH_BYTE, 32'h12);
      wr(TMRTC_LOW_BYTE, 32'h34);
      rd_count(rd_q);
      chk(rd_q, 32'h1234);
   endtask : sc_reset_map
   // One counting window of 64 cycles for every source, ratio and sync choice.
   task automatic sc_rates();
      logic [7:0] tbl [10] = '{8'h40, 8'h50, 8'h60, 8'h70, 8'h00, 8'h04,
                               8'hC0, 8'h80, 8'h84, 8'hB0};
      logic [31:0] lo [10] = '{61, 30, 14, 7, 14, 14, 14, 7, 7, 0};
      logic [31:0] hi [10] = '{67, 34, 18, 9, 18, 18, 18, 9, 9, 2};
      logic [31:0] c;
      for (int i = 0; i < 10; i++) begin
         wr(TMRTC_HIGH_BYTE, 32'h0);
         wr(TMRTC_LOW_BYTE, 32'h0);
         pin_run <= 1'b1;
         wr(TMRTC_CTRL_BYTE, {24'h0, tbl[i] | 8'h01});
         repeat (64) @(posedge sys_clk);
         wr(TMRTC_CTRL_BYTE, {24'h0, tbl[i]});
         pin_run <= 1'b0;
         rd_count(c);
         chk_rng(c, lo[i], hi[i]);
         repeat (20) @(posedge sys_clk);
         rd_count(rd_q);
         chk(rd_q, c);
      end
   endtask : sc_rates
   // A buffered high write must leave the count alone until the low write lands.
   task automatic sc_wide_trig();
      wr(TMRTC_HIGH_BYTE, 32'h12);
      wr(TMRTC_LOW_BYTE, 32'h34);
      wr(TMRTC_CTRL_BYTE, 32'h02);
      wr(TMRTC_HIGH_BYTE, 32'hAB);
      rd_count(rd_q);
      chk(rd_q, 32'h1234);
      wr(TMRTC_HIGH_BYTE, 32'hAB);
      wr(TMRTC_LOW_BYTE, 32'hCD);
      rd_count(rd_q);
      chk(rd_q, 32'hABCD);
      trig_req <= 1'b1;
      @(posedge sys_clk);
      trig_req <= 1'b0;
      repeat (3) @(posedge sys_clk);
      wr(TMRTC_CTRL_BYTE, 32'h00);
      rd_count(rd_q);
      chk(rd_q, 32'h0);
   endtask : sc_wide_trig
   // Restarting the 1:8 divider at every phase must keep the next tick away.
   task automatic sc_restart();
      for (int j = 0; j < 8; j++) begin
         wr(TMRTC_CTRL_BYTE, 32'h71);
         repeat (j + 8) @(posedge sys_clk);
         wr(TMRTC_LOW_BYTE, 32'h0);
         wr(TMRTC_CTRL_BYTE, 32'h70);
         rd(TMRTC_LOW_BYTE);
         chk(rd_q, 32'h0);
      end
   endtask : sc_restart
   task automatic sc_irq_ccp();
      wr(TMRTC_HIGH_BYTE, 32'hFF);
      wr(TMRTC_LOW_BYTE, 32'hFE);
      wr(TMRTC_MASK_BYTE, 32'h1);
      wr(TMRTC_CTRL_BYTE, 32'h41);
      repeat (8) @(posedge sys_clk);
      wr(TMRTC_CTRL_BYTE, 32'h40);
      chk({31'h0, irq}, 32'h1);
      rd(TMRTC_STATUS_BYTE);
      chk(rd_q, 32'h1);
      wr(TMRTC_MASK_BYTE, 32'h0);
      repeat (2) @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      wr(TMRTC_STATUS_BYTE, 32'h1);
      wr(TMRTC_MASK_BYTE, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk({31'h0, irq}, 32'h0);
      rd(TMRTC_STATUS_BYTE);
      chk(rd_q, 32'h0);
      wr(TMRTC_CCP_BYTE, 32'h2);
      repeat (2) @(posedge sys_clk);
      chk({30'h0, ccp}, 32'h2);
   endtask : sc_irq_ccp
   initial begin
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      sc_reset_map();
      sc_rates();
      sc_wide_trig();
      sc_restart();
      sc_irq_ccp();
      report_and_stop();
   end
endmodule : test_timer3_counter_16bit

//--- bench/tmrtc_far_side.sv
`timescale 1ns/10ps
// Stands in for the external count pin and the capture/compare trigger source.
module tmrtc_far_side (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic pin_run,
   input  wire logic trig_req,
   output logic      external_count_pin,
   output logic      special_event_trigger
);
   logic [1:0] phase_q;  // Half-period count, so the pin period is eight cycles.
   // The pin idles low between bursts, so no stray edge is ever offered.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         phase_q <= 2'h0;
         external_count_pin <= 1'b0;
      end else if (pin_run) begin
         phase_q <= phase_q + 2'h1;
         if (phase_q == 2'h3) begin
            external_count_pin <= !external_count_pin;
         end
      end else begin
         phase_q <= 2'h0;
         external_count_pin <= 1'b0;
      end
   end
   // The trigger is a one-cycle pulse, one cycle after the request.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         special_event_trigger <= 1'b0;
      end else begin
         special_event_trigger <= trig_req;
      end
   end
endmodule : tmrtc_far_side

//--- rtl/tmrtc_pkg.sv
package tmrtc_pkg;

   // Register byte addresses on the AXI4-Lite bus.
   localparam logic [11:0] TMRTC_CTRL_ADDR   = 12'hF79;  // Printed control register offset.
   // The byte address is four times the index; the bus decodes only 12 bits, so it aliases.
   localparam logic [11:0] TMRTC_CTRL_BYTE   = 12'(int'(TMRTC_CTRL_ADDR) * 4);
   localparam logic [11:0] TMRTC_LOW_BYTE    = 12'h000;  // Counter low byte.
   localparam logic [11:0] TMRTC_HIGH_BYTE   = 12'h004;  // Counter high byte.
   localparam logic [11:0] TMRTC_STATUS_BYTE = 12'h008;  // Sticky event flags, write one to clear.
   localparam logic [11:0] TMRTC_MASK_BYTE   = 12'h00C;  // Interrupt mask.
   localparam logic [11:0] TMRTC_CCP_BYTE    = 12'h010;  // Capture/compare time base selection.

   // Reset values.
   localparam logic [7:0]  TMRTC_CTRL_RESET  = 8'h00;
   localparam logic [15:0] TMRTC_COUNT_RESET = 16'h0000;

   // Clock source encodings.
   localparam logic [1:0]  TMRTC_SRC_INSTR   = 2'h0;
   localparam logic [1:0]  TMRTC_SRC_SYSTEM  = 2'h1;
   localparam logic [1:0]  TMRTC_SRC_PIN     = 2'h2;

   // Instruction clock is the system clock divided by four.
   localparam int          TMRTC_INSTR_DIV   = 4;

   // AXI response codes.
   localparam logic [1:0]  TMRTC_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  TMRTC_RESP_SLVERR = 2'h2;

   // Control register layout, bit 7 down to bit 0.
   typedef struct packed {
      logic [1:0] count_clock_select;     // Counting source.
      logic [1:0] input_prescale_select;  // Prescale ratio.
      logic       reserved;               // Reads as zero.
      logic       ext_clock_sync_bypass;  // One picks the bypass path, which ticks the same as the synchronised one.
      logic       wide_access_mode;       // One gives 16-bit access through a buffer.
      logic       timer_run;              // One lets the counter advance.
   } tmrtc_ctrl_type;

endpackage : tmrtc_pkg

//--- rtl/tmrtc_prescaler.sv
`timescale 1ns/10ps
// Divides a tick stream by 1, 2, 4 or 8 and can be restarted from zero.
module tmrtc_prescaler (
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic       tick_in,
   input  wire logic [1:0] ratio_sel,
   input  wire logic       restart,
   output logic            tick_out
);
   import tmrtc_pkg::*;

   logic [2:0] count_q;  // Ticks seen since the last output.
   logic [2:0] limit;    // Last count value before an output tick.

   // The ratio field is a power of two exponent.
   always_comb begin
      limit = 3'((4'h1 << ratio_sel) - 4'h1);
   end

   // Count input ticks; restart from software wins over counting.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         count_q  <= 3'h0;
         tick_out <= 1'b0;
      end else if (restart) begin
         count_q  <= 3'h0;
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (tick_in) begin
            if (count_q >= limit) begin
               count_q  <= 3'h0;
               tick_out <= 1'b1;
            end else begin
               count_q <= count_q + 3'h1;
            end
         end
      end
   end

   restart_clears_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      restart |=> count_q == 3'h0) else $error("Prescaler did not restart.");

endmodule : tmrtc_prescaler

//--- rtl/tmrtc_timer.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Overview of operation
// - Sixteen-bit counter, timer or external counter.
// - Counter readable and writable as two bytes.
// - A separate register selects capture/compare time base.
// - Source field picks pin, system or instruction.
// - Prescale divides by one, two, four or eight.
// - Sync bit synchronises pin; ignored internally.
// - Wide mode buffers high byte for 16-bit access.
// - Special event trigger clears the counter.
// - Low byte write restarts the prescaler.
module tmrtc_timer (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        external_count_pin,
   input  wire logic        special_event_trigger,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [1:0]       ccp_time_base,
   output logic             timer_irq
);
   import tmrtc_pkg::*;

   tmrtc_ctrl_type ctrl_q;        // Control register.
   logic [15:0]    count_q;       // The running count.
   logic [7:0]     high_buf_q;    // High byte buffer for wide access.
   logic [1:0]     ccp_sel_q;     // Capture/compare time base selection.
   logic           status_q;      // Sticky overflow flag.
   logic           mask_q;        // Overflow interrupt enable.
   logic [1:0]     instr_div_q;   // Instruction clock divider.
   logic [2:0]     pin_sync_q;    // Two synchroniser stages and an edge history.
   logic           pin_raw_q;     // Single stage history for the bypassed path.
   logic [11:0]    waddr_q;       // Latched write address.
   logic           waddr_ok_q;    // Write address held.
   logic [31:0]    wdata_q;       // Latched write data.
   logic [3:0]     wstrb_q;       // Latched strobes.
   logic           wdata_ok_q;    // Write data held.
   logic           src_tick;      // One tick of the selected source.
   logic           pre_tick;      // Tick after the prescaler.
   logic           wr_fire;       // Both write halves present.
   logic           wr_low;        // Write of low byte lands this cycle.
   logic           wr_high;       // Write of high byte lands this cycle.
   logic           overflow;      // Counter rolls over this cycle.

   // Returns true when the address matches one of the registers.
   function automatic logic addr_mapped(input logic [11:0] a);
      return a == TMRTC_CTRL_BYTE || a == TMRTC_LOW_BYTE || a == TMRTC_HIGH_BYTE ||
             a == TMRTC_STATUS_BYTE || a == TMRTC_MASK_BYTE || a == TMRTC_CCP_BYTE;
   endfunction : addr_mapped

   // Instruction clock divider, free running.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         instr_div_q <= 2'h0;
      end else begin
         instr_div_q <= instr_div_q + 2'h1;
      end
   end

   // The pin passes two flip-flops; a third stage finds the rising edge.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pin_sync_q <= 3'h0;
         pin_raw_q  <= 1'b0;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], external_count_pin};
         pin_raw_q  <= pin_sync_q[1];
      end
   end

   // Source selection. The bypassed path still sits behind the two stages,
   // because this design has one clock; its own history stage matches the edge history stage.
   always_comb begin
      unique case (ctrl_q.count_clock_select)
         TMRTC_SRC_SYSTEM: src_tick = 1'b1;
         TMRTC_SRC_PIN: begin
            if (ctrl_q.ext_clock_sync_bypass) begin
               src_tick = pin_sync_q[1] & ~pin_raw_q;
            end else begin
               src_tick = pin_sync_q[1] & ~pin_sync_q[2];
            end
         end
         default: src_tick = instr_div_q == 2'(TMRTC_INSTR_DIV - 1);
      endcase
   end

   assign wr_fire = waddr_ok_q && wdata_ok_q && !s_axi_bvalid;
   assign wr_low  = wr_fire && waddr_q == TMRTC_LOW_BYTE && wstrb_q[0];
   assign wr_high = wr_fire && waddr_q == TMRTC_HIGH_BYTE && wstrb_q[0];

   tmrtc_prescaler u_prescaler (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .tick_in   (src_tick & ctrl_q.timer_run),
      .ratio_sel (ctrl_q.input_prescale_select),
      .restart   (wr_low),
      .tick_out  (pre_tick)
   );

   assign overflow = pre_tick && ctrl_q.timer_run && count_q == 16'hFFFF;

   // Counter: trigger clear first, then software write, then counting.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         count_q <= TMRTC_COUNT_RESET;
      end else if (special_event_trigger) begin
         count_q <= TMRTC_COUNT_RESET;
      end else if (wr_low) begin
         if (ctrl_q.wide_access_mode) begin
            count_q <= {high_buf_q, wdata_q[7:0]};
         end else begin
            count_q[7:0] <= wdata_q[7:0];
         end
      end else if (wr_high && !ctrl_q.wide_access_mode) begin
         count_q[15:8] <= wdata_q[7:0];
      end else if (pre_tick && ctrl_q.timer_run) begin
         count_q <= count_q + 16'h0001;
      end
   end

   // High byte buffer: loaded by any low byte read or high byte write, in either mode.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         high_buf_q <= 8'h00;
      end else if (wr_high) begin
         high_buf_q <= wdata_q[7:0];
      end else if (s_axi_arvalid && s_axi_arready && s_axi_araddr == TMRTC_LOW_BYTE) begin
         high_buf_q <= count_q[15:8];
      end
   end

   // Control registers written from the bus.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q    <= TMRTC_CTRL_RESET;
         ccp_sel_q <= 2'h0;
         mask_q    <= 1'b0;
      end else if (wr_fire && wstrb_q[0]) begin
         if (waddr_q == TMRTC_CTRL_BYTE) begin
            ctrl_q          <= wdata_q[7:0];
            ctrl_q.reserved <= 1'b0;
         end
         if (waddr_q == TMRTC_CCP_BYTE) begin
            ccp_sel_q <= wdata_q[1:0];
         end
         if (waddr_q == TMRTC_MASK_BYTE) begin
            mask_q <= wdata_q[0];
         end
      end
   end

   // Sticky overflow flag; a new overflow wins over a clear in the same cycle.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         status_q <= 1'b0;
      end else if (overflow) begin
         status_q <= 1'b1;
      end else if (wr_fire && waddr_q == TMRTC_STATUS_BYTE && wstrb_q[0] && wdata_q[0]) begin
         status_q <= 1'b0;
      end
   end

   // Outputs from flip-flops.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         timer_irq     <= 1'b0;
         ccp_time_base <= 2'h0;
      end else begin
         timer_irq     <= status_q & mask_q;
         ccp_time_base <= ccp_sel_q;
      end
   end

   // Write address and data channels, taken in either order.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         waddr_q       <= 12'h000;
         waddr_ok_q    <= 1'b0;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
         wdata_ok_q    <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= TMRTC_RESP_OKAY;
      end else begin
         s_axi_awready <= !waddr_ok_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !wdata_ok_q && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            waddr_q    <= s_axi_awaddr;
            waddr_ok_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q    <= s_axi_wdata;
            wstrb_q    <= s_axi_wstrb;
            wdata_ok_q <= 1'b1;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_mapped(waddr_q) ? TMRTC_RESP_OKAY : TMRTC_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            waddr_ok_q   <= 1'b0;
            wdata_ok_q   <= 1'b0;
         end
      end
   end

   // Read channel: one read at a time, answer one cycle after the address.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= TMRTC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_mapped(s_axi_araddr) ? TMRTC_RESP_OKAY : TMRTC_RESP_SLVERR;
            unique case (s_axi_araddr)
               TMRTC_CTRL_BYTE:   s_axi_rdata <= {24'h000000, ctrl_q};
               TMRTC_LOW_BYTE:    s_axi_rdata <= {24'h000000, count_q[7:0]};
               TMRTC_HIGH_BYTE:   s_axi_rdata <= {24'h000000,
                  ctrl_q.wide_access_mode ? high_buf_q : count_q[15:8]};
               TMRTC_STATUS_BYTE: s_axi_rdata <= {31'h0, status_q};
               TMRTC_MASK_BYTE:   s_axi_rdata <= {31'h0, mask_q};
               TMRTC_CCP_BYTE:    s_axi_rdata <= {30'h0, ccp_sel_q};
               default:           s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks on the counting, the flags and the outputs.
   trig_clears_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      special_event_trigger |=> count_q == 16'h0000) else $error("Trigger did not clear.");
   stop_holds_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      !ctrl_q.timer_run && !special_event_trigger && !wr_fire |=> $stable(count_q))
      else $error("Stopped counter moved.");
   count_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      pre_tick && ctrl_q.timer_run && !special_event_trigger && !wr_fire
      |=> count_q == $past(count_q) + 16'h0001) else $error("Count did not step.");
   overflow_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      overflow |=> status_q ##1 timer_irq == mask_q) else $error("Overflow not flagged.");
   system_rate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      ctrl_q.count_clock_select == TMRTC_SRC_SYSTEM |-> src_tick)
      else $error("System source not ticking.");
   instr_rate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      ctrl_q.count_clock_select == TMRTC_SRC_INSTR && src_tick
      |=> (!src_tick || ctrl_q.count_clock_select != TMRTC_SRC_INSTR) [*3])
      else $error("Instruction source too fast.");
   wide_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == TMRTC_LOW_BYTE && !wr_high
      |=> high_buf_q == $past(count_q[15:8])) else $error("High buffer not loaded.");
   low_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      wr_low && !special_event_trigger |=> count_q[7:0] == $past(wdata_q[7:0]))
      else $error("Low byte write lost.");
   ccp_select_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      ##1 ccp_time_base == $past(ccp_sel_q)) else $error("Time base output stale.");

endmodule : tmrtc_timer
